/* verilog/dpeg_regs.svh */
/*
 * Register offsets, field positions, reset values and widths of the PWM
 * edge generator.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef DPEG_REGS_SVH
`define DPEG_REGS_SVH

`define DPEG_CTRL_OFS      12'h000
`define DPEG_PERIOD_OFS    12'h004
`define DPEG_EV1_OFS       12'h008
`define DPEG_EV2_OFS       12'h00c
`define DPEG_EV3_OFS       12'h010
`define DPEG_EV4_OFS       12'h014
`define DPEG_CYCA_OFS      12'h018
`define DPEG_CYCB_OFS      12'h01c
`define DPEG_ADPS_OFS      12'h020
`define DPEG_PHTRG_OFS     12'h024
`define DPEG_STRG1_OFS     12'h028
`define DPEG_STRG2_OFS     12'h02c
`define DPEG_BLKA_OFS      12'h030
`define DPEG_BLKB_OFS      12'h034
`define DPEG_FILT_OFS      12'h038
`define DPEG_STAT_OFS      12'h03c
`define DPEG_CNT_OFS       12'h040

`define DPEG_CTRL_EN_BIT   0
`define DPEG_CTRL_MODE_LSB 1
`define DPEG_CTRL_PHSEL    4
`define DPEG_CTRL_ASSEL    5
`define DPEG_CTRL_FSRC     6

`define DPEG_CTRL_RST      32'h0000_0000
`define DPEG_PERIOD_RST    16'h00ff
`define DPEG_CNT_W         16

`endif

/* verilog/dpeg_pkg.sv */
/*
 * Types shared by the PWM edge generator files.
 * Assumes the register header is included by its users.
 */
package dpeg_pkg;

  typedef enum logic [2:0] {
    DPEG_MODE_NORMAL = 3'b000,
    DPEG_MODE_MULTI  = 3'b001,
    DPEG_MODE_RESON  = 3'b010,
    DPEG_MODE_TRI    = 3'b011,
    DPEG_MODE_LEAD   = 3'b100
  } dpeg_mode_type;

  // Edge positions for one period, each compared against the counter, plus enable flags
  typedef struct packed {
    logic [15:0] a_rise;
    logic [15:0] a_fall;
    logic [15:0] b_rise;
    logic [15:0] b_fall;
    logic [15:0] adps;
    logic [15:0] phase;
    logic        a_on;
    logic        b_on;
    logic        adps_on;
  } dpeg_edges_type;

  // Filter outputs arriving from the loop filter
  typedef struct packed {
    logic [15:0] duty;
    logic [15:0] period;
  } dpeg_filt_type;

endpackage : dpeg_pkg

/* verilog/dpeg_calc.sv */
/*
 * Edge calculator: turns mode, event values and filter outputs into the
 * edge positions of one period, registered once per clock.
 * Assumes the caller samples the result at the period wrap.
 */
`timescale 1ns/100ps
`include "dpeg_regs.svh"

module dpeg_calc
  import dpeg_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           resetn_i,
  input  wire dpeg_mode_type  mode_i,
  input  wire logic           phsel_i,
  input  wire logic           assel_i,
  input  wire logic [15:0]    ev1_i,
  input  wire logic [15:0]    ev2_i,
  input  wire logic [15:0]    ev3_i,
  input  wire logic [15:0]    ev4_i,
  input  wire logic [15:0]    cyca_i,
  input  wire logic [15:0]    cycb_i,
  input  wire logic [15:0]    adps_i,
  input  wire logic [15:0]    phreg_i,
  input  wire dpeg_filt_type  filt_i,
  output dpeg_edges_type      edges_o
);

  typedef struct packed {
    dpeg_edges_type edges;
  } dpeg_calc_state_type;

  dpeg_calc_state_type st_ff;
  dpeg_calc_state_type nxt_st;
  logic [15:0]         half_d;
  logic [15:0]         half_p;
  logic [15:0]         dt_avg;
  logic [15:0]         eff_d;

  // Edge equations per mode, all modulo the counter width
  always_comb begin
    half_d = {1'b0, filt_i.duty[15:1]};
    half_p = {1'b0, filt_i.period[15:1]};
    dt_avg = 16'((({1'b0, ev2_i - ev1_i}) + ({1'b0, ev4_i - ev3_i})) >> 1);
    eff_d  = 16'(filt_i.duty - dt_avg);
    nxt_st = st_ff;
    nxt_st.edges.a_on    = 1'b1;
    nxt_st.edges.b_on    = 1'b1;
    nxt_st.edges.adps_on = 1'b1;
    // Phase trigger source, all modes
    nxt_st.edges.phase = phsel_i ? filt_i.duty : phreg_i;
    // Sample trigger at end or middle of on-time
    nxt_st.edges.adps = 16'(ev1_i + (assel_i ? half_d : filt_i.duty)
                            + adps_i);
    nxt_st.edges.a_rise = ev1_i;
    nxt_st.edges.a_fall = 16'(ev1_i + filt_i.duty + cyca_i);
    // One mode at a time, from the current filter values
    case (mode_i)
      DPEG_MODE_MULTI: begin
        // Event 2 and 4 unused here
        nxt_st.edges.b_rise = ev3_i;
        nxt_st.edges.b_fall = 16'(ev3_i + filt_i.duty + cycb_i);
      end
      DPEG_MODE_RESON: begin
        // Duty less mean dead time on both outputs
        nxt_st.edges.a_rise = ev1_i;
        nxt_st.edges.a_fall = 16'(ev1_i + eff_d + cyca_i);
        nxt_st.edges.b_rise = 16'(ev1_i + half_p);
        nxt_st.edges.b_fall = 16'(ev1_i + half_p + eff_d + cycb_i);
      end
      DPEG_MODE_TRI: begin
        // Only B, centred in the period
        nxt_st.edges.a_on    = 1'b0;
        nxt_st.edges.adps_on = 1'b0;
        nxt_st.edges.b_rise  = 16'(half_p - half_d + cyca_i);
        nxt_st.edges.b_fall  = 16'(half_p + half_d + cycb_i);
      end
      DPEG_MODE_LEAD: begin
        // Rising edge walks back as duty grows
        nxt_st.edges.a_fall = ev1_i;
        nxt_st.edges.a_rise = 16'(ev1_i - filt_i.duty + cyca_i);
        nxt_st.edges.adps   = 16'(ev1_i - (assel_i ? half_d : filt_i.duty)
                                  + adps_i);
        nxt_st.edges.b_rise = ev4_i;
        nxt_st.edges.b_fall = 16'(ev1_i - filt_i.duty + cyca_i
                                  - (ev2_i - ev3_i));
      end
      default: begin
        // Normal mode: B fills the rest after a dead time
        nxt_st.edges.b_rise = 16'(ev1_i + filt_i.duty + cyca_i
                                  + (ev3_i - ev2_i));
        nxt_st.edges.b_fall = ev4_i;
      end
    endcase
  end

  // Result register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign edges_o = st_ff.edges;

endmodule : dpeg_calc

/* verilog/dpeg_top.sv */
/*
 * PWM edge generator: period counter, APB registers and edge placement of
 * outputs A and B, adaptive sample, phase, sample and blanking triggers.
 * Assumes one clock, an APB master on the same clock and filter outputs
 * from logic on the same clock.
 */
// Notes on behaviour
// - Counter runs zero to period limit, restarts
// - Multi: A rises event 1, width duty+adjust
// - Multi: B rises at event 3
// - Multi: B falls event 3 plus duty+adjust B
// - Multi: events 2 and 4 ignored
// - Multi: B pulse may cross period wrap
// - Multi: A pulse cut at wrap unless event 1 equals limit
// - Sample trigger A at end of on-time
// - Sample trigger A at mid on-time when ASSEL set
// - Phase trigger from register or filter duty
// - Sample and blanking triggers straight from registers
// - Resonant: filter period is twice duty
// - Resonant: mean dead time subtracted from duty
// - Resonant: only A rise fixed to start
// - Triangular: only B pulses, no sample trigger
// - Triangular: B rises half period minus half duty
// - Triangular: B falls half period plus half duty
// - Leading: A falls event 1, rises earlier
// - Leading: sample triggers before event 1
// - Leading: B rises event 4, falls before A
// - Normal: B rises after A plus dead time
`timescale 1ns/100ps
`include "dpeg_regs.svh"

module dpeg_top
  import dpeg_pkg::*;
#(
  parameter int CNT_W = `DPEG_CNT_W
)(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [15:0] filt_duty_i,
  input  wire logic [15:0] filt_period_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             output_a_o,
  output logic             output_b_o,
  output logic             adps_trig_o,
  output logic             phase_trig_o,
  output logic             strg1_o,
  output logic             strg2_o,
  output logic             blank_a_o,
  output logic             blank_b_o,
  output logic             period_wrap_o
);

  typedef struct packed {
    logic [31:0]    ctrl;
    logic [15:0]    period_limit;
    logic [15:0]    ev1;
    logic [15:0]    ev2;
    logic [15:0]    ev3;
    logic [15:0]    ev4;
    logic [15:0]    cyca;
    logic [15:0]    cycb;
    logic [15:0]    adps;
    logic [15:0]    phreg;
    logic [31:0]    strg;
    logic [31:0]    blka;
    logic [31:0]    blkb;
    logic [31:0]    filt_reg;
    logic [15:0]    cnt;
    dpeg_edges_type act;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           out_a;
    logic           out_b;
    logic           adps_trig;
    logic           phase_trig;
    logic           strg1;
    logic           strg2;
    logic           blank_a;
    logic           blank_b;
    logic           wrap;
  } dpeg_state_type;

  dpeg_state_type st_ff;
  dpeg_state_type nxt_st;
  dpeg_edges_type calc_edges;
  dpeg_filt_type  filt;
  dpeg_mode_type  mode;
  logic           enable;
  logic           at_end;
  logic           apb_acc;
  logic [15:0]    cnt_nx;
  dpeg_edges_type next_edges;

  assign enable = st_ff.ctrl[`DPEG_CTRL_EN_BIT];
  assign mode   = dpeg_mode_type'(st_ff.ctrl[`DPEG_CTRL_MODE_LSB +: 3]);
  // Filter outputs from port, or from register for open-loop trials
  assign filt.duty   = st_ff.ctrl[`DPEG_CTRL_FSRC] ?
                       st_ff.filt_reg[15:0] : filt_duty_i;
  assign filt.period = st_ff.ctrl[`DPEG_CTRL_FSRC] ?
                       st_ff.filt_reg[31:16] : filt_period_i;
  assign at_end  = (st_ff.cnt >= st_ff.period_limit);
  assign apb_acc = psel_i & penable_i & st_ff.pready;
  assign cnt_nx  = 16'(st_ff.cnt + 16'h0001);

  // Edge positions for the coming period
  dpeg_calc u_calc (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .mode_i   (mode),
    .phsel_i  (st_ff.ctrl[`DPEG_CTRL_PHSEL]),
    .assel_i  (st_ff.ctrl[`DPEG_CTRL_ASSEL]),
    .ev1_i    (st_ff.ev1),
    .ev2_i    (st_ff.ev2),
    .ev3_i    (st_ff.ev3),
    .ev4_i    (st_ff.ev4),
    .cyca_i   (st_ff.cyca),
    .cycb_i   (st_ff.cycb),
    .adps_i   (st_ff.adps),
    .phreg_i  (st_ff.phreg),
    .filt_i   (filt),
    .edges_o  (calc_edges)
  );

  // In multi mode B may run past the wrap: fold its fall into the period
  always_comb begin
    next_edges = calc_edges;
    if (mode == DPEG_MODE_MULTI &&
        calc_edges.b_fall > st_ff.period_limit) begin
      next_edges.b_fall = 16'(calc_edges.b_fall - st_ff.period_limit
                              - 16'h0001);
    end
  end

  // Next-state logic: bus, counter, edges
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wrap = 1'b0;
    nxt_st.adps_trig = 1'b0;
    nxt_st.phase_trig = 1'b0;
    nxt_st.strg1 = 1'b0;
    nxt_st.strg2 = 1'b0;
    // APB: one wait state, answer in the access phase
    nxt_st.pready = psel_i & penable_i & ~st_ff.pready;
    if (apb_acc && pwrite_i) begin
      case (paddr_i)
        `DPEG_CTRL_OFS:   nxt_st.ctrl = pwdata_i;
        `DPEG_PERIOD_OFS: nxt_st.period_limit = pwdata_i[15:0];
        `DPEG_EV1_OFS:    nxt_st.ev1 = pwdata_i[15:0];
        `DPEG_EV2_OFS:    nxt_st.ev2 = pwdata_i[15:0];
        `DPEG_EV3_OFS:    nxt_st.ev3 = pwdata_i[15:0];
        `DPEG_EV4_OFS:    nxt_st.ev4 = pwdata_i[15:0];
        `DPEG_CYCA_OFS:   nxt_st.cyca = pwdata_i[15:0];
        `DPEG_CYCB_OFS:   nxt_st.cycb = pwdata_i[15:0];
        `DPEG_ADPS_OFS:   nxt_st.adps = pwdata_i[15:0];
        `DPEG_PHTRG_OFS:  nxt_st.phreg = pwdata_i[15:0];
        `DPEG_STRG1_OFS:  nxt_st.strg[15:0] = pwdata_i[15:0];
        `DPEG_STRG2_OFS:  nxt_st.strg[31:16] = pwdata_i[15:0];
        `DPEG_BLKA_OFS:   nxt_st.blka = pwdata_i;
        `DPEG_BLKB_OFS:   nxt_st.blkb = pwdata_i;
        `DPEG_FILT_OFS:   nxt_st.filt_reg = pwdata_i;
        default: ;
      endcase
    end
    // Read mux, registered and shown with pready
    nxt_st.prdata = 32'h0000_0000;
    nxt_st.pslverr = 1'b0;
    if (psel_i && penable_i && !st_ff.pready) begin
      case (paddr_i)
        `DPEG_CTRL_OFS:   nxt_st.prdata = st_ff.ctrl;
        `DPEG_PERIOD_OFS: nxt_st.prdata = {16'h0000, st_ff.period_limit};
        `DPEG_EV1_OFS:    nxt_st.prdata = {16'h0000, st_ff.ev1};
        `DPEG_EV2_OFS:    nxt_st.prdata = {16'h0000, st_ff.ev2};
        `DPEG_EV3_OFS:    nxt_st.prdata = {16'h0000, st_ff.ev3};
        `DPEG_EV4_OFS:    nxt_st.prdata = {16'h0000, st_ff.ev4};
        `DPEG_CYCA_OFS:   nxt_st.prdata = {16'h0000, st_ff.cyca};
        `DPEG_CYCB_OFS:   nxt_st.prdata = {16'h0000, st_ff.cycb};
        `DPEG_ADPS_OFS:   nxt_st.prdata = {16'h0000, st_ff.adps};
        `DPEG_PHTRG_OFS:  nxt_st.prdata = {16'h0000, st_ff.phreg};
        `DPEG_STRG1_OFS:  nxt_st.prdata = {16'h0000, st_ff.strg[15:0]};
        `DPEG_STRG2_OFS:  nxt_st.prdata = {16'h0000, st_ff.strg[31:16]};
        `DPEG_BLKA_OFS:   nxt_st.prdata = st_ff.blka;
        `DPEG_BLKB_OFS:   nxt_st.prdata = st_ff.blkb;
        `DPEG_FILT_OFS:   nxt_st.prdata = st_ff.filt_reg;
        `DPEG_STAT_OFS:   nxt_st.prdata = {26'h0, st_ff.blank_b,
                            st_ff.blank_a, st_ff.out_b, st_ff.out_a,
                            enable, st_ff.act.a_on};
        `DPEG_CNT_OFS:    nxt_st.prdata = {16'h0000, st_ff.cnt};
        default:          nxt_st.pslverr = 1'b1;
      endcase
    end
    if (!enable) begin
      // Idle: counter held at zero, outputs low
      nxt_st.cnt = 16'h0000;
      nxt_st.out_a = 1'b0;
      nxt_st.out_b = 1'b0;
      nxt_st.blank_a = 1'b0;
      nxt_st.blank_b = 1'b0;
      nxt_st.act = next_edges;
    end else begin
      // Free-running counter, zero to limit
      nxt_st.cnt = at_end ? 16'h0000 : cnt_nx;
      if (at_end) begin
        // Take fresh edges at the wrap
        nxt_st.act = next_edges;
        nxt_st.wrap = 1'b1;
        // In multi mode the A pulse is cut at the wrap unless A rises on the last count
        if (mode == DPEG_MODE_MULTI) begin
          nxt_st.out_a = 1'b0;
        end
      end
      // Output A edges, suppressed in triangular mode
      if (st_ff.act.a_on && st_ff.cnt == st_ff.act.a_rise) begin
        nxt_st.out_a = 1'b1;
      end else if (st_ff.act.a_on && st_ff.cnt == st_ff.act.a_fall) begin
        nxt_st.out_a = 1'b0;
      end
      if (!st_ff.act.a_on) begin
        nxt_st.out_a = 1'b0;
      end
      // B keeps level across the wrap so its width holds
      if (st_ff.cnt == st_ff.act.b_rise) begin
        nxt_st.out_b = 1'b1;
      end else if (st_ff.cnt == st_ff.act.b_fall) begin
        nxt_st.out_b = 1'b0;
      end
      nxt_st.adps_trig = st_ff.act.adps_on &&
                         (st_ff.cnt == st_ff.act.adps);
      nxt_st.phase_trig = (st_ff.cnt == st_ff.act.phase);
      // Fixed triggers and windows from registers
      nxt_st.strg1 = (st_ff.cnt == st_ff.strg[15:0]);
      nxt_st.strg2 = (st_ff.cnt == st_ff.strg[31:16]);
      if (st_ff.cnt == st_ff.blka[15:0]) nxt_st.blank_a = 1'b1;
      else if (st_ff.cnt == st_ff.blka[31:16]) nxt_st.blank_a = 1'b0;
      if (st_ff.cnt == st_ff.blkb[15:0]) nxt_st.blank_b = 1'b1;
      else if (st_ff.cnt == st_ff.blkb[31:16]) nxt_st.blank_b = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.ctrl <= `DPEG_CTRL_RST;
      st_ff.period_limit <= `DPEG_PERIOD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o      = st_ff.prdata;
  assign pready_o      = st_ff.pready;
  assign pslverr_o     = st_ff.pslverr;
  assign output_a_o    = st_ff.out_a;
  assign output_b_o    = st_ff.out_b;
  assign adps_trig_o   = st_ff.adps_trig;
  assign phase_trig_o  = st_ff.phase_trig;
  assign strg1_o       = st_ff.strg1;
  assign strg2_o       = st_ff.strg2;
  assign blank_a_o     = st_ff.blank_a;
  assign blank_b_o     = st_ff.blank_b;
  assign period_wrap_o = st_ff.wrap;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  cnt_wrap_a: assert property (
    enable && at_end |=> st_ff.cnt == 16'h0000)
    else $error("counter did not wrap");
  cnt_step_a: assert property (
    enable && !at_end |=> st_ff.cnt == $past(cnt_nx))
    else $error("counter did not step");
  a_rise_a: assert property (
    enable && st_ff.act.a_on && st_ff.cnt == st_ff.act.a_rise
    |=> output_a_o)
    else $error("output a missed rise");
  b_rise_a: assert property (
    enable && st_ff.cnt == st_ff.act.b_rise |=> output_b_o)
    else $error("output b missed rise");
  b_fall_a: assert property (
    enable && st_ff.cnt == st_ff.act.b_fall
    && st_ff.cnt != st_ff.act.b_rise |=> !output_b_o)
    else $error("output b missed fall");
  a_nowrap_a: assert property (
    enable && at_end && mode == DPEG_MODE_MULTI
    && st_ff.act.a_rise != st_ff.cnt |=> !output_a_o)
    else $error("output a crossed wrap");
  tri_quiet_a: assert property (
    !st_ff.act.a_on |=> !output_a_o && !adps_trig_o)
    else $error("triangular mode a active");
  ph_trig_a: assert property (
    enable && st_ff.cnt == st_ff.act.phase |=> phase_trig_o)
    else $error("phase trigger missed");
  strg_fix_a: assert property (
    enable && st_ff.cnt == st_ff.strg[15:0] |=> strg1_o)
    else $error("sample trigger 1 missed");
  apb_wait_a: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer late");

  // Falling edges, wrap hold, triggers and windows
  a_fall_a: assert property (
    enable && st_ff.act.a_on && st_ff.cnt == st_ff.act.a_fall
    && st_ff.cnt != st_ff.act.a_rise |=> !output_a_o)
    else $error("output a missed fall");
  b_hold_a: assert property (
    enable && at_end && mode == DPEG_MODE_MULTI && output_b_o
    && st_ff.cnt != st_ff.act.b_fall |=> output_b_o)
    else $error("output b cut at wrap");
  adps_hit_a: assert property (
    enable && st_ff.act.adps_on && st_ff.cnt == st_ff.act.adps
    |=> adps_trig_o)
    else $error("adaptive sample trigger missed");
  ph_quiet_a: assert property (
    enable && st_ff.cnt != st_ff.act.phase |=> !phase_trig_o)
    else $error("phase trigger out of place");
  strg2_fix_a: assert property (
    enable && st_ff.cnt == st_ff.strg[31:16] |=> strg2_o)
    else $error("sample trigger 2 missed");
  blank_on_a: assert property (
    enable && st_ff.cnt == st_ff.blka[15:0] |=> blank_a_o)
    else $error("blanking a missed begin");
  blank_off_a: assert property (
    enable && st_ff.cnt == st_ff.blkb[31:16]
    && st_ff.cnt != st_ff.blkb[15:0] |=> !blank_b_o)
    else $error("blanking b missed end");
  edge_hold_a: assert property (
    enable && !at_end |=> $stable(st_ff.act))
    else $error("edges changed mid-period");

  cov_wrap_c: cover property (period_wrap_o);
  cov_b_wrap_c: cover property (output_b_o && period_wrap_o);
  cov_multi_c: cover property (mode == DPEG_MODE_MULTI && output_a_o);
  cov_tri_c: cover property (mode == DPEG_MODE_TRI && output_b_o);
  cov_lead_c: cover property (mode == DPEG_MODE_LEAD && period_wrap_o);

endmodule : dpeg_top

/* dv/dpeg_drv_model.sv */
/*
 * Gate driver model of the PWM edge generator: places every edge of the
 * drive, trigger and window lines against the start of the period.
 * Assumes the wrap pulse marks counter zero, all on one clock.
 */
`timescale 1ns/100ps

module dpeg_drv_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       wrap_i,
  input  wire logic [7:0] sig_i
);
  logic [15:0] pos;
  logic [15:0] plen;
  logic [7:0]  last;
  logic [15:0] rise_pos [8];
  logic [15:0] fall_pos [8];
  int          rises    [8];

  // Edge seen at count p was placed at p-1, one cycle output delay
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos = 16'h0000;
      last = 8'h00;
    end else begin
      if (wrap_i) begin
        plen = pos + 16'h0001;
        pos = 16'h0000;
      end else begin
        pos = pos + 16'h0001;
      end
      for (int i = 0; i < 8; i++) begin
        if (sig_i[i] && !last[i]) begin
          rise_pos[i] = pos - 16'h0001;
          rises[i]++;
        end
        if (!sig_i[i] && last[i]) begin
          fall_pos[i] = pos - 16'h0001;
        end
      end
      last = sig_i;
    end
  end

endmodule : dpeg_drv_model

/* dv/dpwm_mode_edge_generator_tb_top.sv */
/*
 * Bench of the PWM edge generator: APB access, edge placement per mode
 * from a table, fixed triggers, windows and reset.
 * Assumes design files, package, header and driver model compile first.
 */
`timescale 1ns/100ps
`include "dpeg_regs.svh"

module dpwm_mode_edge_generator_tb_top
  import dpeg_pkg::*;
;
  localparam logic [7:0] NONE = 8'hfe;
  localparam logic [7:0] SKIP = 8'hff;

  typedef struct packed {
    dpeg_mode_type    mode;
    logic             assel;
    logic [0:5][7:0]  prog;
    logic [7:0]       duty;
    logic [7:0]       per;
    logic [0:4][7:0]  exp;
  } dpeg_row_type;

  // Events 1-4, adjusts A/B; duty, period; A rise/fall, B rise/fall, sample
  localparam dpeg_row_type ROWS [6] = '{
    '{DPEG_MODE_MULTI, 1'b0, '{8'h10, 8'h99, 8'h40, 8'h77, 8'h02, 8'h05},
      8'h30, 8'hfe,
      '{8'h10, 8'h42, 8'h40, 8'h75, 8'h44}},
    '{DPEG_MODE_MULTI, 1'b1, '{8'h10, 8'h99, 8'he0, 8'h77, 8'h00, 8'h00},
      8'h40, 8'hfe,
      '{8'h10, 8'h50, 8'he0, 8'h20, 8'h34}},
    '{DPEG_MODE_TRI, 1'b0, '{8'h10, 8'h99, 8'h40, 8'h77, 8'h01, 8'h03},
      8'h20, 8'hfe,
      '{NONE, NONE, 8'h70, 8'h92, NONE}},
    '{DPEG_MODE_LEAD, 1'b0, '{8'h90, 8'h20, 8'h10, 8'hc0, 8'h02, 8'h00},
      8'h30, 8'hfe,
      '{8'h62, 8'h90, 8'hc0, 8'h52, 8'h64}},
    '{DPEG_MODE_NORMAL, 1'b0, '{8'h10, 8'h50, 8'h58, 8'hc0, 8'h02, 8'h07},
      8'h30, 8'hfe,
      '{8'h10, 8'h42, 8'h4a, 8'hc0, 8'h44}},
    '{DPEG_MODE_RESON, 1'b0, '{8'h08, 8'h10, 8'h80, 8'h8c, 8'h00, 8'h00},
      8'h7f, 8'hfe,
      '{8'h08, 8'h7d, 8'h87, 8'hfc, SKIP}}
  };

  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [15:0] fduty;
  logic [15:0] fper;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        oa;
  logic        ob;
  logic        adps;
  logic        ph;
  logic        s1;
  logic        s2;
  logic        bla;
  logic        blb;
  logic        wrap;
  logic [31:0] rdata;
  logic        rerr;
  logic [7:0]  e;
  logic [15:0] got;
  int          base [8];
  int          err_total;
  int          comparisons;
  wire  [8:0]  outs = {oa, ob, adps, ph, s1, s2, bla, blb, wrap};

  dpeg_top DUT (
    .clk_i         (clk),
    .resetn_i      (resetn),
    .psel_i        (psel),
    .penable_i     (penable),
    .pwrite_i      (pwrite),
    .paddr_i       (paddr),
    .pwdata_i      (pwdata),
    .filt_duty_i   (fduty),
    .filt_period_i (fper),
    .prdata_o      (prdata),
    .pready_o      (pready),
    .pslverr_o     (pslverr),
    .output_a_o    (oa),
    .output_b_o    (ob),
    .adps_trig_o   (adps),
    .phase_trig_o  (ph),
    .strg1_o       (s1),
    .strg2_o       (s2),
    .blank_a_o     (bla),
    .blank_b_o     (blb),
    .period_wrap_o (wrap)
  );

  dpeg_drv_model DRV (
    .clk_i    (clk),
    .resetn_i (resetn),
    .wrap_i   (wrap),
    .sig_i    ({blb, bla, s2, s1, ph, adps, ob, oa})
  );

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever begin
      #25 clk = ~clk;
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask : apb

  // Waits for k period starts, then steps off the edge
  task automatic wraps(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (wrap !== 1'b1 && n < 600);
      if (wrap !== 1'b1) begin
        err_total++;
        end_of_test();
      end
    end
    #1;
  endtask : wraps

  function automatic logic [31:0] ctl(dpeg_mode_type m, logic [2:0] sel);
    return {25'h0, sel, m, 1'b1};
  endfunction : ctl

  // Programs events, adjusts, filter outputs and mode of one row
  task automatic cfg(input dpeg_row_type r, input logic [2:0] sel);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, `DPEG_EV1_OFS + 12'(4 * k), {24'h0, r.prog[k]});
    end
    fduty <= {8'h00, r.duty};
    fper  <= {8'h00, r.per};
    apb(1'b1, `DPEG_CTRL_OFS, ctl(r.mode, sel));
  endtask : cfg

  // Main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fduty = 16'h0000;
    fper = 16'h0000;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    check({23'h0, outs}, 32'h0);
    apb(1'b0, `DPEG_CTRL_OFS, 32'h0);
    check(rdata, `DPEG_CTRL_RST);
    apb(1'b0, `DPEG_PERIOD_OFS, 32'h0);
    check(rdata, {16'h0, `DPEG_PERIOD_RST});
    apb(1'b0, 12'h0fc, 32'h0);
    check({rerr, rdata[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h0f8, 32'h5);
    check({31'h0, rerr}, 32'h1);
    apb(1'b1, `DPEG_EV1_OFS, 32'h1234);
    apb(1'b0, `DPEG_EV1_OFS, 32'h0);
    check(rdata, 32'h1234);
    apb(1'b1, `DPEG_ADPS_OFS, 32'h4);
    // Table of modes, positions and pulse counts over two periods
    foreach (ROWS[i]) begin
      cfg(ROWS[i], {1'b0, ROWS[i].assel, 1'b0});
      wraps(3);
      base = DRV.rises;
      wraps(2);
      for (int j = 0; j < 5; j++) begin
        e = ROWS[i].exp[j];
        got = j[0] ? DRV.fall_pos[j / 2] : DRV.rise_pos[j / 2];
        if (e < NONE) begin
          check({16'h0, got}, {24'h0, e});
        end
        if (!j[0] && e != SKIP) begin
          check(DRV.rises[j / 2] - base[j / 2], e == NONE ? 0 : 2);
        end
      end
    end
    // Shorter period, fixed triggers and windows from registers
    apb(1'b1, `DPEG_PERIOD_OFS, 32'h7f);
    apb(1'b1, `DPEG_PHTRG_OFS, 32'h21);
    apb(1'b1, `DPEG_STRG1_OFS, 32'h33);
    apb(1'b1, `DPEG_STRG2_OFS, 32'h55);
    apb(1'b1, `DPEG_BLKA_OFS, 32'h0060_0020);
    apb(1'b1, `DPEG_BLKB_OFS, 32'h0070_0030);
    cfg(ROWS[0], 3'b000);
    wraps(3);
    check({16'h0, DRV.plen}, 32'h80);
    check({16'h0, DRV.rise_pos[3]}, 32'h21);
    check({DRV.rise_pos[4], DRV.rise_pos[5]}, 32'h0033_0055);
    check({DRV.rise_pos[6], DRV.fall_pos[6]}, 32'h0020_0060);
    check({DRV.rise_pos[7], DRV.fall_pos[7]}, 32'h0030_0070);
    // A pushed past the wrap; phase from duty held in register
    apb(1'b1, `DPEG_FILT_OFS, 32'h00fe_0024);
    apb(1'b1, `DPEG_EV1_OFS, 32'h60);
    apb(1'b1, `DPEG_CTRL_OFS, ctl(DPEG_MODE_MULTI, 3'b101));
    wraps(3);
    check({16'h0, DRV.rise_pos[3]}, 32'h24);
    check({16'h0, DRV.rise_pos[0]}, 32'h60);
    check({31'h0, DRV.fall_pos[0] + 16'h0001 <= 16'h0001}, 32'h1);
    // Reset in mid-run clears outputs and control
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check({23'h0, outs}, 32'h0);
    resetn <= 1'b1;
    apb(1'b0, `DPEG_CTRL_OFS, 32'h0);
    check(rdata, `DPEG_CTRL_RST);
    end_of_test();
  end

endmodule : dpwm_mode_edge_generator_tb_top
